// ---- verilog/scp_pkg.sv ----
// Purpose: Shared constants for the serial configuration port
// Assumes: 10 MHz system clock on both ends
// Notes:   Word layout, bank codes, bank sizes and link timing
package scp_pkg;
  // Word layout
  localparam int unsigned WORD_W   = 32;
  localparam int unsigned PAY_W    = 27;
  localparam int unsigned PAY_LSB  = 5;
  localparam int unsigned BANK_MSB = 4;
  localparam int unsigned BANK_LSB = 3;
  localparam int unsigned REG_MSB  = 2;
  localparam int unsigned REG_LSB  = 0;
  localparam int unsigned BANKS    = 4;
  localparam int unsigned REGS_MAX = 8;

  // Bank codes
  localparam logic [1:0] BANK_NVM  = 2'h0;
  localparam logic [1:0] BANK_TXS  = 2'h1;
  localparam logic [1:0] BANK_RXS  = 2'h2;
  localparam logic [1:0] BANK_FUNC = 2'h3;

  // Registers per bank
  localparam logic [3:0] NREG_NVM  = 4'h3;
  localparam logic [3:0] NREG_SYN  = 4'h6;
  localparam logic [3:0] NREG_FUNC = 4'h8;

  // Reset values
  localparam logic [PAY_W-1:0]  PAY_RST  = 27'h0;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0;

  // Timing, system clock and link
  localparam int unsigned CLK_NS       = 100;
  localparam int unsigned SCLK_HALF_NS = 400;
  localparam int unsigned LATCH_NS     = 400;
  localparam int unsigned GAP_NS       = 800;
  localparam int unsigned SCLK_HALF_CYC =
    (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LATCH_CYC = (LATCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GAP_CYC   = (GAP_NS + CLK_NS - 1) / CLK_NS;

  // True when a bank holds the given register number
  function automatic logic reg_exists(input logic [1:0] bank,
                                      input logic [2:0] idx);
    logic [3:0] n;
    n = NREG_NVM;
    case (bank)
      BANK_TXS, BANK_RXS: n = NREG_SYN;
      BANK_FUNC:          n = NREG_FUNC;
      default:            n = NREG_NVM;
    endcase
    return ({1'b0, idx} < n);
  endfunction
endpackage

// ---- verilog/scp_if.sv ----
// Purpose: Three-wire programming link plus readback pin
// Assumes: All pins single direction, no tristate
// Notes:   Bench connects host and device modports
`timescale 1ns/1ps
interface scp_if;
  logic prog_serial_clock;
  logic prog_serial_data_in;
  logic prog_latch_strobe;
  logic prog_readback_out;

  modport host (
    output prog_serial_clock,
    output prog_serial_data_in,
    output prog_latch_strobe,
    input  prog_readback_out
  );
  modport dev (
    input  prog_serial_clock,
    input  prog_serial_data_in,
    input  prog_latch_strobe,
    output prog_readback_out
  );
endinterface

// ---- verilog/scp_dev.sv ----
// Purpose: Device end of the serial configuration port
// Assumes: Link pins asynchronous, oversampled by i_clk_sys
// Notes:   Readback returns the addressed register's previous word;
//          each link pin must hold a level for one or more system
//          clocks, or an edge on it may be missed
`timescale 1ns/1ps

module scp_dev (
  // Link
  scp_if.dev                           link,
  // Clock, reset, enable
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rst_b,
  input  wire logic                    i_ce,
  // Write report
  output logic                         o_wr_pulse,
  output logic [1:0]                   o_wr_bank,
  output logic [2:0]                   o_wr_reg,
  output logic [scp_pkg::PAY_W-1:0]    o_wr_payload,
  output logic                         o_bad_addr,
  output logic                         o_func0_pulse
);
  import scp_pkg::*;

  // Synchroniser chains: [0] first stage, [1] second, [2] previous
  logic [2:0]             sck_s_r;
  logic [2:0]             sck_s_nxt;
  logic [1:0]             dat_s_r;
  logic [1:0]             dat_s_nxt;
  logic [2:0]             lat_s_r;
  logic [2:0]             lat_s_nxt;
  logic                   sck_rise;
  logic                   lat_rise;

  // Shift and readback state
  logic [WORD_W-1:0]      shift_r;
  logic [WORD_W-1:0]      shift_nxt;
  logic [WORD_W-1:0]      rb_sh_r;
  logic [WORD_W-1:0]      rb_sh_nxt;
  logic                   rb_out_r;
  logic                   rb_out_nxt;

  // Register banks. Every bank gets eight slots so the address indexes
  // directly; slots beyond a bank's size are never written.
  logic [PAY_W-1:0]       mem_r   [BANKS][REGS_MAX];
  logic [PAY_W-1:0]       mem_nxt [BANKS][REGS_MAX];

  // Report outputs
  logic                   wr_pulse_r;
  logic                   wr_pulse_nxt;
  logic [1:0]             wr_bank_r;
  logic [1:0]             wr_bank_nxt;
  logic [2:0]             wr_reg_r;
  logic [2:0]             wr_reg_nxt;
  logic [PAY_W-1:0]       wr_pay_r;
  logic [PAY_W-1:0]       wr_pay_nxt;
  logic                   bad_r;
  logic                   bad_nxt;
  logic                   func0_r;
  logic                   func0_nxt;

  // Decoded address of the word in the shift register; it only means
  // something once all 32 bits have arrived
  logic [1:0]             a_bank;
  logic [2:0]             a_reg;
  logic                   a_ok;

  // Edges are taken from the second stage against the previous one.
  // A pulse shorter than a system clock period can be lost entirely.
  assign sck_rise = sck_s_r[1] & ~sck_s_r[2];
  assign lat_rise = lat_s_r[1] & ~lat_s_r[2];

  // Address fields of the received word
  assign a_bank = shift_r[BANK_MSB:BANK_LSB];
  assign a_reg  = shift_r[REG_MSB:REG_LSB];
  assign a_ok   = reg_exists(a_bank, a_reg);

  // Synchronisers, next values. Two stages guard against a pin that
  // moves near the sampling edge; the third stage only remembers the
  // previous level for edge detection and adds no latency, since the
  // edge is seen as soon as the second stage rises.
  always_comb begin
    sck_s_nxt = {sck_s_r[1:0], link.prog_serial_clock};
    dat_s_nxt = {dat_s_r[0], link.prog_serial_data_in};
    lat_s_nxt = {lat_s_r[1:0], link.prog_latch_strobe};
  end

  // Synchronisers, registers
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sck_s_r <= 3'h0;
      dat_s_r <= 2'h0;
      lat_s_r <= 3'h0;
    end else if (i_ce) begin
      sck_s_r <= sck_s_nxt;
      dat_s_r <= dat_s_nxt;
      lat_s_r <= lat_s_nxt;
    end
  end

  // Shift, latch decode and readback, next values.
  // Latch wins over a clock edge in the same cycle; a well behaved
  // host never does both, so nothing is lost in practice.
  always_comb begin
    shift_nxt = shift_r;
    rb_sh_nxt = rb_sh_r;
    mem_nxt   = mem_r;
    if (lat_rise) begin
      // Latch is not tied to the serial clock, so only its edge counts
      if (a_ok) begin
        mem_nxt[a_bank][a_reg] = shift_r[WORD_W-1:PAY_LSB];
        // Old contents go out on readback during the next word
        rb_sh_nxt = {mem_r[a_bank][a_reg], shift_r[PAY_LSB-1:0]};
      end else begin
        // Unknown address: nothing stored, readback shows zeros
        rb_sh_nxt = WORD_RST;
      end
    end else if (sck_rise) begin
      shift_nxt = {dat_s_r[1], shift_r[WORD_W-1:1]};
      rb_sh_nxt = {1'b0, rb_sh_r[WORD_W-1:1]};
    end
    rb_out_nxt = rb_sh_nxt[0];
  end

  // Report outputs, next values. Bank, register and payload hold
  // until the next commit, so a slow consumer may read them after
  // the one-cycle pulse has gone.
  always_comb begin
    wr_pulse_nxt = 1'b0;
    wr_bank_nxt  = wr_bank_r;
    wr_reg_nxt   = wr_reg_r;
    wr_pay_nxt   = wr_pay_r;
    bad_nxt      = 1'b0;
    func0_nxt    = 1'b0;
    if (lat_rise) begin
      if (a_ok) begin
        wr_pulse_nxt = 1'b1;
        wr_bank_nxt  = a_bank;
        wr_reg_nxt   = a_reg;
        wr_pay_nxt   = shift_r[WORD_W-1:PAY_LSB];
        func0_nxt    = (a_bank == BANK_FUNC) && (a_reg == 3'h0);
      end else begin
        // Refused addresses are reported rather than silently dropped
        bad_nxt = 1'b1;
      end
    end
  end

  // Shift, banks and readback, registers. The banks are plain flops;
  // a much larger bank count would call for a memory instead.
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_r  <= WORD_RST;
      rb_sh_r  <= WORD_RST;
      rb_out_r <= 1'b0;
      for (int b = 0; b < BANKS; b++) begin
        for (int r = 0; r < REGS_MAX; r++) begin
          mem_r[b][r] <= PAY_RST;
        end
      end
    end else if (i_ce) begin
      shift_r  <= shift_nxt;
      rb_sh_r  <= rb_sh_nxt;
      rb_out_r <= rb_out_nxt;
      mem_r    <= mem_nxt;
    end
  end

  // Report outputs, registers
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_pulse_r <= 1'b0;
      wr_bank_r  <= 2'h0;
      wr_reg_r   <= 3'h0;
      wr_pay_r   <= PAY_RST;
      bad_r      <= 1'b0;
      func0_r    <= 1'b0;
    end else if (i_ce) begin
      wr_pulse_r <= wr_pulse_nxt;
      wr_bank_r  <= wr_bank_nxt;
      wr_reg_r   <= wr_reg_nxt;
      wr_pay_r   <= wr_pay_nxt;
      bad_r      <= bad_nxt;
      func0_r    <= func0_nxt;
    end
  end

  // Every output straight from a flip-flop, so whatever listens sees
  // no decode glitches
  assign link.prog_readback_out = rb_out_r;
  assign o_wr_pulse    = wr_pulse_r;
  assign o_wr_bank     = wr_bank_r;
  assign o_wr_reg      = wr_reg_r;
  assign o_wr_payload  = wr_pay_r;
  assign o_bad_addr    = bad_r;
  assign o_func0_pulse = func0_r;
endmodule

// ---- verilog/scp_host.sv ----
// Purpose: Host end, writes one word and collects readback
// Assumes: Device oversamples the link with a similar clock
// Notes:   Serial clock derived by a divider of i_clk_sys
`timescale 1ns/1ps
module scp_host #(
  parameter int unsigned HALF_CYC  = scp_pkg::SCLK_HALF_CYC,
  parameter int unsigned LATCH_CYC = scp_pkg::LATCH_CYC,
  parameter int unsigned GAP_CYC   = scp_pkg::GAP_CYC
) (
  // Link
  scp_if.host                          link,
  // Clock, reset, enable
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rst_b,
  input  wire logic                    i_ce,
  // Command
  input  wire logic                    i_start,
  input  wire logic [scp_pkg::WORD_W-1:0] i_word,
  output logic                         o_busy,
  output logic                         o_done,
  output logic [scp_pkg::WORD_W-1:0]   o_rd_word
);
  import scp_pkg::*;

  typedef enum logic [2:0] {
    SCPH_IDLE, SCPH_LOW, SCPH_HIGH, SCPH_SETUP, SCPH_LATCH, SCPH_GAP
  } scph_state_t;

  scph_state_t        st_r, st_nxt;
  logic [15:0]        cnt_r, cnt_nxt;
  logic [4:0]         bit_r, bit_nxt;
  logic [WORD_W-1:0]  sh_r, sh_nxt;
  logic [WORD_W-1:0]  rd_r, rd_nxt;
  logic [WORD_W-1:0]  rdo_r, rdo_nxt;
  logic               sck_r, sck_nxt;
  logic               sda_r, sda_nxt;
  logic               lat_r, lat_nxt;
  logic               busy_r, busy_nxt;
  logic               done_r, done_nxt;
  logic [1:0]         rb_s_r;
  logic [1:0]         rb_s_nxt;

  // Readback pin is foreign to this clock: two stages first
  always_comb begin
    rb_s_nxt = {rb_s_r[0], link.prog_readback_out};
  end

  // Readback synchroniser, registers
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rb_s_r <= 2'h0;
    end else if (i_ce) begin
      rb_s_r <= rb_s_nxt;
    end
  end

  // Sequencer, next values. Half period of four cycles by default keeps
  // the serial clock far below the port's maximum rate.
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    rd_nxt   = rd_r;
    rdo_nxt  = rdo_r;
    sck_nxt  = sck_r;
    sda_nxt  = sda_r;
    lat_nxt  = lat_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    case (st_r)
      SCPH_IDLE: begin
        if (i_start) begin
          sh_nxt   = i_word;
          sda_nxt  = i_word[0];
          bit_nxt  = 5'h0;
          cnt_nxt  = 16'(HALF_CYC - 1);
          busy_nxt = 1'b1;
          st_nxt   = SCPH_LOW;
        end
      end
      SCPH_LOW: begin
        if (cnt_r == 16'h0) begin
          // Sample readback just before the rise that moves it on
          rd_nxt  = {rb_s_r[1], rd_r[WORD_W-1:1]};
          sck_nxt = 1'b1;
          cnt_nxt = 16'(HALF_CYC - 1);
          st_nxt  = SCPH_HIGH;
        end else begin
          cnt_nxt = cnt_r - 16'h1;
        end
      end
      SCPH_HIGH: begin
        if (cnt_r == 16'h0) begin
          sck_nxt = 1'b0;
          cnt_nxt = 16'(HALF_CYC - 1);
          if (bit_r == 5'h1f) begin
            st_nxt = SCPH_SETUP;
          end else begin
            bit_nxt = bit_r + 5'h1;
            sh_nxt  = {1'b0, sh_r[WORD_W-1:1]};
            sda_nxt = sh_r[1];
            st_nxt  = SCPH_LOW;
          end
        end else begin
          cnt_nxt = cnt_r - 16'h1;
        end
      end
      SCPH_SETUP: begin
        if (cnt_r == 16'h0) begin
          lat_nxt = 1'b1;
          cnt_nxt = 16'(LATCH_CYC - 1);
          st_nxt  = SCPH_LATCH;
        end else begin
          cnt_nxt = cnt_r - 16'h1;
        end
      end
      SCPH_LATCH: begin
        if (cnt_r == 16'h0) begin
          lat_nxt = 1'b0;
          cnt_nxt = 16'(GAP_CYC - 1);
          st_nxt  = SCPH_GAP;
        end else begin
          cnt_nxt = cnt_r - 16'h1;
        end
      end
      SCPH_GAP: begin
        // Quiet time so a calibration started by this word can end
        if (cnt_r == 16'h0) begin
          rdo_nxt  = rd_r;
          done_nxt = 1'b1;
          busy_nxt = 1'b0;
          st_nxt   = SCPH_IDLE;
        end else begin
          cnt_nxt = cnt_r - 16'h1;
        end
      end
      default: begin
        st_nxt   = SCPH_IDLE;
        sck_nxt  = 1'b0;
        lat_nxt  = 1'b0;
        busy_nxt = 1'b0;
      end
    endcase
  end

  // Sequencer, registers
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r   <= SCPH_IDLE;
      cnt_r  <= 16'h0;
      bit_r  <= 5'h0;
      sh_r   <= WORD_RST;
      rd_r   <= WORD_RST;
      rdo_r  <= WORD_RST;
      sck_r  <= 1'b0;
      sda_r  <= 1'b0;
      lat_r  <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (i_ce) begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      bit_r  <= bit_nxt;
      sh_r   <= sh_nxt;
      rd_r   <= rd_nxt;
      rdo_r  <= rdo_nxt;
      sck_r  <= sck_nxt;
      sda_r  <= sda_nxt;
      lat_r  <= lat_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign link.prog_serial_clock   = sck_r;
  assign link.prog_serial_data_in = sda_r;
  assign link.prog_latch_strobe   = lat_r;
  assign o_busy    = busy_r;
  assign o_done    = done_r;
  assign o_rd_word = rdo_r;
endmodule

// ---- bench/scp_link_sva.sv ----
// Purpose: Link-level checks between host and device ends
// Assumes: Host built with its default divider counts
// Notes:   Sees only link pins plus the system clock and reset
`timescale 1ns/1ps
module scp_link_sva (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Link pins
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data_in,
  input wire logic prog_latch_strobe,
  input wire logic prog_readback_out
);
  logic       sck_d_r;
  logic       le_d_r;
  logic [5:0] rise_cnt_r;
  logic [5:0] rise_cnt_nxt;
  logic [3:0] since_r;
  logic [3:0] since_nxt;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  // Count serial clock rises per word, cleared when the latch drops
  always_comb begin
    rise_cnt_nxt = rise_cnt_r;
    since_nxt    = (since_r == 4'hf) ? since_r : since_r + 4'h1;
    if (le_d_r && !prog_latch_strobe) begin
      rise_cnt_nxt = 6'h0;
    end else if (prog_serial_clock && !sck_d_r) begin
      rise_cnt_nxt = rise_cnt_r + 6'h1;
    end
    // Saturating age of the last link edge, bounds readback changes
    if ((prog_serial_clock && !sck_d_r) ||
        (prog_latch_strobe && !le_d_r)) begin
      since_nxt = 4'h0;
    end
  end

  // History registers only
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sck_d_r    <= 1'b0;
      le_d_r     <= 1'b0;
      rise_cnt_r <= 6'h0;
      since_r    <= 4'hf;
    end else begin
      sck_d_r    <= prog_serial_clock;
      le_d_r     <= prog_latch_strobe;
      rise_cnt_r <= rise_cnt_nxt;
      since_r    <= since_nxt;
    end
  end

  AST_LATCH_AFTER_32: assert property (
    $rose(prog_latch_strobe) |-> rise_cnt_r == 6'd32)
    else $error("latch rose without exactly 32 clock rises");
  AST_DATA_MOVES_LOW: assert property (
    $changed(prog_serial_data_in) |-> !prog_serial_clock)
    else $error("data changed while serial clock high");
  AST_DATA_SETUP: assert property (
    $rose(prog_serial_clock) |->
      $past(prog_serial_data_in, 3) == prog_serial_data_in)
    else $error("data not settled before clock rise");
  AST_BIT_SPACING: assert property (
    $rose(prog_serial_clock) && rise_cnt_r < 6'd31 |->
      ##8 $rose(prog_serial_clock))
    else $error("next bit clock not eight cycles later");
  AST_CLOCK_HIGH: assert property (
    $rose(prog_serial_clock) |->
      prog_serial_clock[*4] ##1 !prog_serial_clock)
    else $error("serial clock high time wrong");
  AST_LATCH_CLK_LOW: assert property (
    prog_latch_strobe |-> !prog_serial_clock)
    else $error("serial clock high during latch");
  AST_LATCH_SETUP: assert property (
    $rose(prog_latch_strobe) |-> $past(prog_serial_clock, 4) == 1'b0)
    else $error("latch too close to last clock rise");
  AST_LATCH_WIDTH: assert property (
    $rose(prog_latch_strobe) |->
      prog_latch_strobe[*4] ##1 !prog_latch_strobe)
    else $error("latch pulse width wrong");
  AST_GAP_AFTER_LATCH: assert property (
    $rose(prog_latch_strobe) |-> !prog_serial_clock[*8])
    else $error("clock resumed too soon after latch");
  AST_READBACK_TIMED: assert property (
    $changed(prog_readback_out) |-> since_r <= 4'd6)
    else $error("readback moved away from a link edge");

  // Main scenarios
  COV_LATCH: cover property ($rose(prog_latch_strobe));
  COV_FULL_WORD: cover property (rise_cnt_r == 6'd32);
  COV_READBACK: cover property ($changed(prog_readback_out));
endmodule

// ---- bench/testbench.sv ----
// Purpose: Host and device ends joined, words written and read back
// Assumes: Both ends share one 10 MHz clock and one reset
// Notes:   Readback of a transfer shows what the previous word replaced
`timescale 1ns/1ps
module testbench;
  import scp_pkg::*;
  logic              clk_sys, rst_b, start, busy, done;
  logic              wr_pulse, bad_addr, func0_pulse;
  logic [WORD_W-1:0] word, rd_word, rb_exp;
  logic [1:0]        wr_bank;
  logic [2:0]        wr_reg;
  logic [PAY_W-1:0]  wr_payload;
  logic [PAY_W-1:0]  model [4][8];
  logic [WORD_W:0]   rows [11];
  int                n_fail, n_tests, cyc, n_wr, n_bad, n_f0;

  scp_if link ();
  scp_host i_scp_host (.link(link), .i_clk_sys(clk_sys),
    .i_rst_b(rst_b), .i_ce(1'b1), .i_start(start), .i_word(word),
    .o_busy(busy), .o_done(done), .o_rd_word(rd_word));
  scp_dev i_scp_dev (.link(link), .i_clk_sys(clk_sys), .i_rst_b(rst_b),
    .i_ce(1'b1), .o_wr_pulse(wr_pulse), .o_wr_bank(wr_bank),
    .o_wr_reg(wr_reg), .o_wr_payload(wr_payload),
    .o_bad_addr(bad_addr), .o_func0_pulse(func0_pulse));
  scp_link_sva i_scp_link_sva (.i_clk_sys(clk_sys), .i_rst_b(rst_b),
    .prog_serial_clock(link.prog_serial_clock),
    .prog_serial_data_in(link.prog_serial_data_in),
    .prog_latch_strobe(link.prog_latch_strobe),
    .prog_readback_out(link.prog_readback_out));

  // System clock
  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  // Hang guard, about twice the expected run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic check(input logic [WORD_W-1:0] seen,
                       input logic [WORD_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One word through the host; entered at a falling edge
  task automatic send(input logic [WORD_W-1:0] w);
    n_wr  = 0;
    n_bad = 0;
    n_f0  = 0;
    start = 1'b1;
    word  = w;
    @(negedge clk_sys);
    word = ~w;  // Start still high while busy, so must be ignored
    @(negedge clk_sys);
    start = 1'b0;
    for (int k = 0; k < 400 && done !== 1'b1; k++) begin
      @(negedge clk_sys);
      n_wr  += (wr_pulse === 1'b1);
      n_bad += (bad_addr === 1'b1);
      n_f0  += (func0_pulse === 1'b1);
    end
    check({31'h0, done}, 32'h1);
  endtask

  // Send one row and compare commit flags, fields and readback
  task automatic do_row(input logic [WORD_W:0] row);
    logic [WORD_W-1:0] w;
    logic              ok;
    logic              f0;
    w  = row[WORD_W-1:0];
    ok = row[WORD_W];
    f0 = ok && w[4:3] == BANK_FUNC && w[2:0] == 3'h0;
    send(w);
    check(rd_word, rb_exp);
    check(32'(n_wr), {31'h0, ok});
    check(32'(n_bad), {31'h0, !ok});
    check(32'(n_f0), {31'h0, f0});
    if (ok) begin
      check({wr_payload, wr_bank, wr_reg}, w);
    end
    rb_exp = ok ? {model[w[4:3]][w[2:0]], w[4:0]} : 32'h0;
    if (ok) begin
      model[w[4:3]][w[2:0]] = w[31:5];
    end
  endtask

  initial begin
    // Valid flag beside the word; low five bits pick bank and register
    rows = '{33'h1_a5a5_a5a2, 33'h0_1234_5603, 33'h1_ffff_ffed,
             33'h0_0000_002e, 33'h1_8000_0010, 33'h0_5555_5557,
             33'h1_dead_bef8, 33'h1_7fff_ff1f, 33'h1_c0de_0018,
             33'h1_0bad_ca4d, 33'h1_1357_9be0};
    foreach (model[b, r]) model[b][r] = PAY_RST;
    rb_exp  = WORD_RST;
    rst_b   = 1'b0;
    start   = 1'b0;
    word    = 32'h0;
    n_fail  = 0;
    n_tests = 0;
    cyc     = 0;
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    // Ordinary writes, back to back
    foreach (rows[i]) do_row(rows[i]);
    // Reset in mid-word drops the word and clears both ends
    start = 1'b1;
    word  = rows[2][WORD_W-1:0];
    @(negedge clk_sys);
    start = 1'b0;
    repeat (100) @(negedge clk_sys);
    rst_b = 1'b0;
    repeat (2) @(negedge clk_sys);
    check({1'b0, busy, link.prog_serial_clock, link.prog_latch_strobe,
           link.prog_readback_out, wr_payload}, 32'h0);
    rst_b = 1'b1;
    foreach (model[b, r]) model[b][r] = PAY_RST;
    rb_exp = WORD_RST;
    // Same register twice: second readback returns the reset payload the first write replaced
    do_row(rows[4]);
    do_row(rows[4]);
    complete_run();
  end
endmodule
